// File: rst_seq_pkg.sv
package rst_seq_pkg;

  // Core clock rate
  localparam int unsigned CLK_MHZ = 250;

  // Ceiling division of a time in ns to cycles at CLK_MHZ
  function automatic int unsigned ns_to_cyc(input int unsigned ns);
    ns_to_cyc = (ns * CLK_MHZ + 999) / 1000;
  endfunction

  // Times in ns, as specified
  localparam int unsigned WAKE_PREP_NS     = 20000;   // Least deep sleep release wait
  localparam int unsigned PROC_1ST_LVD_NS  = 672000;  // First ext release, detector used
  localparam int unsigned PROC_1ST_NOLV_NS = 399000;  // First ext release, no detector
  localparam int unsigned PROC_NXT_LVD_NS  = 531000;  // Later ext release, detector used
  localparam int unsigned PROC_NXT_NOLV_NS = 259000;  // Later ext release, no detector
  localparam int unsigned STAB_TYP_NS      = 990000;  // Supply stabilisation wait
  localparam int unsigned STAB_MAX_NS      = 2300000; // Upper bound of that wait

  // Cycle counts
  localparam int unsigned WAKE_PREP_CYC     = ns_to_cyc(WAKE_PREP_NS);
  localparam int unsigned PROC_1ST_LVD_CYC  = ns_to_cyc(PROC_1ST_LVD_NS);
  localparam int unsigned PROC_1ST_NOLV_CYC = ns_to_cyc(PROC_1ST_NOLV_NS);
  localparam int unsigned PROC_NXT_LVD_CYC  = ns_to_cyc(PROC_NXT_LVD_NS);
  localparam int unsigned PROC_NXT_NOLV_CYC = ns_to_cyc(PROC_NXT_NOLV_NS);
  localparam int unsigned STAB_CYC          = ns_to_cyc(STAB_TYP_NS);
  localparam int unsigned PLL_LOCK_CYC      = 1024;   // Plain default lock time
  localparam int unsigned ISR_DELAY_CYC     = 14;     // Core IRQ valid to ISR start

  // Wait counter width
  localparam int unsigned CNT_W = 20;

  // Interrupt lines seen by the wake logic
  localparam int unsigned IRQ_W = 32;

  // Reset cause bit positions
  localparam int unsigned SRC_EXT  = 0;
  localparam int unsigned SRC_WDT  = 1;
  localparam int unsigned SRC_POR  = 2;
  localparam int unsigned SRC_LVD  = 3;
  localparam int unsigned SRC_SW   = 4;
  localparam int unsigned SRC_PAR  = 5;
  localparam int unsigned SRC_ILL  = 6;
  localparam int unsigned SRC_OSTP = 7;
  localparam int unsigned SRC_N    = 8;

  // Reset causes, bit i matches SRC_* above
  typedef logic [SRC_N-1:0] reset_sources_t;

  // Oscillator enables
  typedef struct packed {
    logic hoco;    // Internal high-speed
    logic xtal;    // Main crystal
    logic subxtal; // Sub crystal
    logic loco;    // Internal low-speed
    logic ext_clk; // External main and sub clock inputs accepted
  } osc_en_t;

  localparam osc_en_t OSC_ALL_OFF = 5'h00;
  localparam osc_en_t OSC_RUN_ON  = 5'h1F;

  // Core clock source in use before deep sleep
  typedef enum logic [1:0] {
    CLK_HOCO,
    CLK_EXT,
    CLK_XTAL,
    CLK_PLL
  } clk_src_t;

  // Crystal settle time per select code, plain defaults in cycles
  function automatic logic [CNT_W-1:0] settle_cyc(input logic [2:0] sel);
    settle_cyc = CNT_W'(32'h0000_0100) << sel;
  endfunction

endpackage

// File: rst_release_sync.sv
`timescale 1ns/100ps

// Asserts at once on the request, releases two edges after it drops
module rst_release_sync (
  input  wire logic ref_clk_i, // Core clock
  input  wire logic req_i,     // Merged reset request, active high
  output logic      rel_n_o    // Synchronised release, low while held
);

  logic meta_q; // First stage, read only by the second

  // Asynchronous assertion, clocked release
  always_ff @(posedge ref_clk_i or posedge req_i) begin
    if (req_i) begin
      meta_q  <= 1'b0;
      rel_n_o <= 1'b0;
    end else begin
      meta_q  <= 1'b1;
      rel_n_o <= meta_q;
    end
  end

endmodule

// File: rst_sequencer.sv
`timescale 1ns/100ps

module rst_sequencer #(
  parameter int unsigned WAKE_PREP_CYC = rst_seq_pkg::WAKE_PREP_CYC,
  parameter int unsigned PROC_1L_CYC   = rst_seq_pkg::PROC_1ST_LVD_CYC,
  parameter int unsigned PROC_1N_CYC   = rst_seq_pkg::PROC_1ST_NOLV_CYC,
  parameter int unsigned PROC_NL_CYC   = rst_seq_pkg::PROC_NXT_LVD_CYC,
  parameter int unsigned PROC_NN_CYC   = rst_seq_pkg::PROC_NXT_NOLV_CYC,
  parameter int unsigned STAB_CYC      = rst_seq_pkg::STAB_CYC
) (
  input  wire logic                            ref_clk_i,
  input  wire logic                            rst_n_i,
  input  wire logic                            external_reset_pin_n_i,
  input  wire logic                            wdt_overflow_i,
  input  wire logic                            por_detect_i,
  input  wire logic                            supply_level_detector_i,
  input  wire logic                            software_system_reset_request_i,
  input  wire logic                            ram_parity_error_i,
  input  wire logic                            illegal_access_i,
  input  wire logic                            osc_stop_reset_i,
  input  wire logic                            supply_detect_control_i,
  input  wire logic                            sleep_enter_i,
  input  wire rst_seq_pkg::clk_src_t           clk_src_i,
  input  wire logic [2:0]                      osc_settle_select_i,
  input  wire logic [rst_seq_pkg::IRQ_W-1:0]   irq_pending_i,
  input  wire logic [rst_seq_pkg::IRQ_W-1:0]   irq_mask_i,
  output logic                                 sys_reset_n_o,
  output logic                                 core_run_o,
  output logic                                 sleeping_o,
  output logic                                 reset_vector_fetch_o,
  output logic                                 core_irq_o,
  output logic                                 isr_start_o,
  output rst_seq_pkg::osc_en_t                 osc_en_o,
  output logic                                 core_clk_hoco_o,
  output logic                                 wdt_reset_o,
  output logic                                 detector_logic_reset_o,
  output logic                                 rtc_run_o,
  output rst_seq_pkg::reset_sources_t          reset_cause_flags_o,
  output logic                                 debug_port_pin_a_o,
  output logic                                 debug_port_pin_a_oe_o,
  output logic                                 debug_port_pin_b_o,
  output logic                                 debug_port_pin_b_oe_o
);

  // Sequencer states
  typedef enum logic [2:0] {
    ST_HOLD,  // Reset asserted
    ST_STAB,  // Supply stabilisation wait
    ST_PROC,  // Reset processing
    ST_RUN,   // Normal operation
    ST_SLEEP, // Deep sleep
    ST_WAKE,  // Release preparation
    ST_IRQ    // Core IRQ to ISR start
  } seq_state_t;

  seq_state_t                          state_q;     // Current state
  rst_seq_pkg::reset_sources_t         src;         // Live sources
  rst_seq_pkg::reset_sources_t         held_src_q;  // Sources of reset in progress
  logic                                merged_req;  // Any source active
  logic                                rel_n;       // Synchronised release
  logic [rst_seq_pkg::CNT_W-1:0]       cnt_q;       // Wait counter
  logic [rst_seq_pkg::CNT_W-1:0]       wake_cyc;    // Wake wait length
  logic [rst_seq_pkg::CNT_W-1:0]       proc_cyc;    // Processing length
  logic                                first_done_q;// An ext release seen since POR
  logic                                wake_req;    // Unmasked pending interrupt
  logic                                ext_por;     // Held reset is ext or POR

  // Source merge, pin is active low
  always_comb begin
    src = '0;
    src[rst_seq_pkg::SRC_EXT]  = ~external_reset_pin_n_i;
    src[rst_seq_pkg::SRC_WDT]  = wdt_overflow_i;
    src[rst_seq_pkg::SRC_POR]  = por_detect_i;
    src[rst_seq_pkg::SRC_LVD]  = supply_level_detector_i;
    src[rst_seq_pkg::SRC_SW]   = software_system_reset_request_i;
    src[rst_seq_pkg::SRC_PAR]  = ram_parity_error_i;
    src[rst_seq_pkg::SRC_ILL]  = illegal_access_i;
    src[rst_seq_pkg::SRC_OSTP] = osc_stop_reset_i;
  end

  // One request, all sources treated alike
  // Block reset joins as a source
  assign merged_req = (|src) | ~rst_n_i;

  // Immediate assertion, synchronised release
  // Only the release edge meets the clock
  rst_release_sync u_release (
    .ref_clk_i (ref_clk_i),
    .req_i     (merged_req),
    .rel_n_o   (rel_n)
  );

  // Supply sources drop once supply is above threshold
  // Output is the second sync stage itself
  assign sys_reset_n_o = rel_n;

  // Interrupt wake condition, mask bit clear
  assign wake_req = |(irq_pending_i & ~irq_mask_i);

  // Release preparation length per clock source
  // Source must hold steady during sleep
  always_comb begin
    wake_cyc = rst_seq_pkg::CNT_W'(WAKE_PREP_CYC);
    case (clk_src_i)
      rst_seq_pkg::CLK_XTAL: begin
        // Longer of 20us and settle time
        if (rst_seq_pkg::settle_cyc(osc_settle_select_i) > wake_cyc) begin
          wake_cyc = rst_seq_pkg::settle_cyc(osc_settle_select_i);
        end
      end
      rst_seq_pkg::CLK_PLL: begin
        // Lock time added
        wake_cyc = wake_cyc + rst_seq_pkg::CNT_W'(rst_seq_pkg::PLL_LOCK_CYC);
      end
      default: begin
        wake_cyc = rst_seq_pkg::CNT_W'(WAKE_PREP_CYC);
      end
    endcase
  end

  // Processing length from cause, history and detector use
  // Held causes: live ones are gone here
  always_comb begin
    if (held_src_q[rst_seq_pkg::SRC_EXT] && !first_done_q) begin
      proc_cyc = supply_detect_control_i ? rst_seq_pkg::CNT_W'(PROC_1L_CYC)
                                         : rst_seq_pkg::CNT_W'(PROC_1N_CYC);
    end else if (supply_detect_control_i) begin
      proc_cyc = rst_seq_pkg::CNT_W'(PROC_NL_CYC);
    end else begin
      proc_cyc = rst_seq_pkg::CNT_W'(PROC_NN_CYC);
    end
  end

  // External or power-on reset in progress
  // Keeps debug pins floating in the tail
  assign ext_por = held_src_q[rst_seq_pkg::SRC_EXT] | held_src_q[rst_seq_pkg::SRC_POR];

  // Main sequencer and its wait counter
  // Ends compare with >= so none can wedge
  always_ff @(posedge ref_clk_i) begin
    if (!rel_n) begin
      // Any source, any state, even deep sleep
      state_q <= ST_HOLD;
      cnt_q   <= '0;
    end else begin
      case (state_q)
        ST_HOLD: begin
          // Self release once sources drop
          cnt_q <= '0;
          if (held_src_q[rst_seq_pkg::SRC_POR]) begin
            state_q <= ST_STAB;
          end else begin
            state_q <= ST_PROC;
          end
        end
        ST_STAB: begin
          // Stabilisation before processing
          if (cnt_q >= rst_seq_pkg::CNT_W'(STAB_CYC - 1)) begin
            cnt_q   <= '0;
            state_q <= ST_PROC;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        ST_PROC: begin
          // Processing, then restart from vector
          if (cnt_q >= proc_cyc - 1'b1) begin
            cnt_q   <= '0;
            state_q <= ST_RUN;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        ST_RUN: begin
          // Enter deep sleep on request
          cnt_q <= '0;
          if (sleep_enter_i) begin
            state_q <= ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          // Only unmasked interrupt wakes here
          cnt_q <= '0;
          if (wake_req) begin
            state_q <= ST_WAKE;
          end
        end
        ST_WAKE: begin
          // Release preparation
          if (cnt_q >= wake_cyc - 1'b1) begin
            cnt_q   <= '0;
            state_q <= ST_IRQ;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        ST_IRQ: begin
          // Fixed latency to ISR
          if (cnt_q >= rst_seq_pkg::CNT_W'(rst_seq_pkg::ISR_DELAY_CYC - 1)) begin
            cnt_q   <= '0;
            state_q <= ST_RUN;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        default: begin
          cnt_q   <= '0;
          state_q <= ST_HOLD;
        end
      endcase
    end
  end

  // Sources of the reset in progress, cleared on normal running
  // ORed in hold so late joiners stay
  always_ff @(posedge ref_clk_i) begin
    if (!rel_n) begin
      if (state_q == ST_HOLD) begin
        held_src_q <= held_src_q | src;
      end else begin
        held_src_q <= src;
      end
    end else if (state_q == ST_PROC && cnt_q >= proc_cyc - 1'b1) begin
      held_src_q <= '0;
    end
  end

  // Cause flags of the latest reset, POR clears history
  always_ff @(posedge ref_clk_i) begin
    if (src[rst_seq_pkg::SRC_POR]) begin
      reset_cause_flags_o <= rst_seq_pkg::reset_sources_t'(1) << rst_seq_pkg::SRC_POR;
    end else if (!rst_n_i) begin
      // Block reset leaves no recorded cause
      reset_cause_flags_o <= '0;
    end else if (!rel_n && state_q != ST_HOLD) begin
      reset_cause_flags_o <= src;
    end else if (!rel_n) begin
      reset_cause_flags_o <= reset_cause_flags_o | src;
    end
  end

  // First external release after POR tracking
  always_ff @(posedge ref_clk_i) begin
    // Block reset counts as a fresh power-up
    if (src[rst_seq_pkg::SRC_POR] || !rst_n_i) begin
      first_done_q <= 1'b0;
    end else if (state_q == ST_PROC && held_src_q[rst_seq_pkg::SRC_EXT]
                 && cnt_q >= proc_cyc - 1'b1) begin
      first_done_q <= 1'b1;
    end
  end

  // Core control outputs
  // Fetch pulse and run start share the processing terminal-count term
  always_ff @(posedge ref_clk_i) begin
    if (!rel_n) begin
      core_run_o           <= 1'b0;
      sleeping_o           <= 1'b0;
      reset_vector_fetch_o <= 1'b0;
      core_irq_o           <= 1'b0;
      isr_start_o          <= 1'b0;
    end else begin
      // Run from vector after processing
      reset_vector_fetch_o <= (state_q == ST_PROC) && (cnt_q >= proc_cyc - 1'b1);
      core_run_o  <= (state_q == ST_RUN) || (state_q == ST_IRQ) ||
                     ((state_q == ST_PROC) && (cnt_q >= proc_cyc - 1'b1));
      sleeping_o  <= (state_q == ST_SLEEP) || (state_q == ST_WAKE) ||
                     ((state_q == ST_RUN) && sleep_enter_i);
      // Core IRQ pulses for one cycle as the wake wait ends
      core_irq_o  <= (state_q == ST_WAKE) && (cnt_q >= wake_cyc - 1'b1);
      isr_start_o <= (state_q == ST_IRQ) &&
                     (cnt_q == rst_seq_pkg::CNT_W'(rst_seq_pkg::ISR_DELAY_CYC - 1));
    end
  end

  // Clock control, all stopped while reset is held
  // Hold state covered as well as sync tail
  always_ff @(posedge ref_clk_i) begin
    if (!rel_n || state_q == ST_HOLD) begin
      osc_en_o        <= rst_seq_pkg::OSC_ALL_OFF;
      core_clk_hoco_o <= 1'b1;
    end else begin
      osc_en_o        <= rst_seq_pkg::OSC_RUN_ON;
      // Restart always on HOCO, software may switch later
      core_clk_hoco_o <= 1'b1;
    end
  end

  // Side resets for watchdog, detector and RTC
  // RTC gated by the live power-on level
  always_ff @(posedge ref_clk_i) begin
    // Watchdog cleared by every reset
    wdt_reset_o <= ~rel_n || (state_q == ST_HOLD);
    // Detector logic spared by its own reset
    detector_logic_reset_o <= ~rel_n && ((held_src_q | src) !=
                              (rst_seq_pkg::reset_sources_t'(1) << rst_seq_pkg::SRC_LVD));
    // RTC stops only on power-on reset
    rtc_run_o <= ~src[rst_seq_pkg::SRC_POR];
  end

  // Debug pins: float in ext/POR reset, else pulled high
  // Live sources cover the first edge
  always_ff @(posedge ref_clk_i) begin
    debug_port_pin_a_o <= 1'b1;
    debug_port_pin_b_o <= 1'b1;
    if ((!rel_n || state_q == ST_HOLD) &&
        (ext_por || src[rst_seq_pkg::SRC_EXT] || src[rst_seq_pkg::SRC_POR])) begin
      debug_port_pin_a_oe_o <= 1'b0;
      debug_port_pin_b_oe_o <= 1'b0;
    end else begin
      debug_port_pin_a_oe_o <= 1'b1;
      debug_port_pin_b_oe_o <= 1'b1;
    end
  end

endmodule

// File: rst_seq_checker.sv
`timescale 1ns/100ps

// Watches the sequencer ports for reset and wake ordering
module rst_seq_checker (
  input wire logic                          ref_clk_i,
  input wire logic                          rst_n_i,
  input wire logic                          external_reset_pin_n_i,
  input wire logic                          wdt_overflow_i,
  input wire logic                          por_detect_i,
  input wire logic                          supply_level_detector_i,
  input wire logic                          software_system_reset_request_i,
  input wire logic                          ram_parity_error_i,
  input wire logic                          illegal_access_i,
  input wire logic                          osc_stop_reset_i,
  input wire logic [rst_seq_pkg::IRQ_W-1:0] irq_pending_i,
  input wire logic [rst_seq_pkg::IRQ_W-1:0] irq_mask_i,
  input wire logic                          sys_reset_n_o,
  input wire logic                          core_run_o,
  input wire logic                          sleeping_o,
  input wire logic                          reset_vector_fetch_o,
  input wire logic                          core_irq_o,
  input wire logic                          isr_start_o,
  input wire rst_seq_pkg::osc_en_t          osc_en_o,
  input wire logic                          core_clk_hoco_o,
  input wire logic                          wdt_reset_o,
  input wire logic                          detector_logic_reset_o,
  input wire logic                          rtc_run_o,
  input wire logic                          debug_port_pin_a_o,
  input wire logic                          debug_port_pin_a_oe_o,
  input wire logic                          debug_port_pin_b_o,
  input wire logic                          debug_port_pin_b_oe_o
);
  logic other_any; // Any source but the supply-level one
  logic src_any;   // Any source requesting reset

  // Merge of the sources as seen at the pins
  assign other_any = !external_reset_pin_n_i | wdt_overflow_i | por_detect_i
                   | software_system_reset_request_i | ram_parity_error_i
                   | illegal_access_i | osc_stop_reset_i;
  assign src_any   = other_any | supply_level_detector_i;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  // System reset seen low on two edges
  sequence s_held;
    !sys_reset_n_o [*2];
  endsequence

  a_src_forces_reset: assert property (src_any |-> !sys_reset_n_o)
    else $error("active source without system reset");
  a_release_sync: assert property ($fell(src_any) |-> s_held ##[1:2] sys_reset_n_o)
    else $error("system reset release not synchronised");
  a_osc_stopped: assert property (s_held |-> osc_en_o == rst_seq_pkg::OSC_ALL_OFF)
    else $error("oscillators running in reset");
  a_wdt_held: assert property (s_held |-> wdt_reset_o)
    else $error("watchdog not reset");
  a_oe_float: assert property ((!external_reset_pin_n_i || por_detect_i) [*2]
    |-> !debug_port_pin_a_oe_o && !debug_port_pin_b_oe_o)
    else $error("debug pins driven in pin or power-on reset");
  a_oe_pulled: assert property ((src_any && external_reset_pin_n_i && !por_detect_i) [*2]
    |-> debug_port_pin_a_oe_o && debug_port_pin_b_oe_o && debug_port_pin_a_o && debug_port_pin_b_o)
    else $error("debug pins not high in internal reset");
  a_rtc_por: assert property (por_detect_i [*2] |-> !rtc_run_o)
    else $error("clock of day running in power-on reset");
  a_lvd_spares: assert property ((supply_level_detector_i && !other_any) [*2]
    |-> !detector_logic_reset_o)
    else $error("detector logic reset by its own reset");
  a_detector_release: assert property ($fell(supply_level_detector_i) && !other_any
    |-> (!detector_logic_reset_o) [*3])
    else $error("detector logic reset after its own reset");
  a_isr_delay: assert property (core_irq_o |-> ##14 (isr_start_o || !sys_reset_n_o))
    else $error("service start not 14 cycles after request");
  a_masked_stay: assert property (sleeping_o && !src_any && !(|(irq_pending_i & ~irq_mask_i))
    |=> sleeping_o || !sys_reset_n_o)
    else $error("left sleep without cause");
  a_vector_hoco: assert property (reset_vector_fetch_o
    |-> core_run_o && core_clk_hoco_o && sys_reset_n_o && osc_en_o == rst_seq_pkg::OSC_RUN_ON)
    else $error("restart not on internal oscillator");
endmodule

bind rst_sequencer rst_seq_checker rst_seq_checker_i (
  .ref_clk_i, .rst_n_i, .external_reset_pin_n_i, .wdt_overflow_i, .por_detect_i,
  .supply_level_detector_i, .software_system_reset_request_i, .ram_parity_error_i,
  .illegal_access_i, .osc_stop_reset_i, .irq_pending_i, .irq_mask_i, .sys_reset_n_o,
  .core_run_o, .sleeping_o, .reset_vector_fetch_o, .core_irq_o, .isr_start_o, .osc_en_o,
  .core_clk_hoco_o, .wdt_reset_o, .detector_logic_reset_o, .rtc_run_o, .debug_port_pin_a_o,
  .debug_port_pin_a_oe_o, .debug_port_pin_b_o, .debug_port_pin_b_oe_o
);

// File: reset_supply_model.sv
`timescale 1ns/100ps

// Reset pin driver and supply supervisors on the far side
module reset_supply_model #(
  parameter int unsigned PIN_MIN_CYC = 2500 // Least pin low time in cycles
) (
  input  wire logic ref_clk_i,              // Core clock
  output logic      external_reset_pin_n_o, // Reset pin, high when idle
  output logic      por_detect_o,           // Power-on supervisor
  output logic      supply_level_detector_o // Supply-level supervisor
);
  int unsigned held_q; // Cycles the pin has been low

  // Supplies good, pin released
  initial begin
    external_reset_pin_n_o = 1'b1;
    por_detect_o = 1'b0;
    supply_level_detector_o = 1'b0;
  end

  // Pin low time
  always @(posedge ref_clk_i) begin
    held_q <= external_reset_pin_n_o ? 0 : held_q + 1;
  end

  // Raise one request, called at a rising edge
  task automatic press(input int unsigned src);
    case (src)
      rst_seq_pkg::SRC_EXT: external_reset_pin_n_o <= 1'b0;
      rst_seq_pkg::SRC_POR: por_detect_o <= 1'b1;
      default: supply_level_detector_o <= 1'b1;
    endcase
  endtask

  // Drop it, keeping the pin low long enough
  task automatic lift(input int unsigned src);
    do @(posedge ref_clk_i);
    while (src == rst_seq_pkg::SRC_EXT && held_q < PIN_MIN_CYC);
    case (src)
      rst_seq_pkg::SRC_EXT: external_reset_pin_n_o <= 1'b1;
      rst_seq_pkg::SRC_POR: por_detect_o <= 1'b0;
      default: supply_level_detector_o <= 1'b0;
    endcase
  endtask
endmodule

// File: deep_sleep_wake_and_reset_sequencer_tb.sv
`timescale 1ns/100ps

module deep_sleep_wake_and_reset_sequencer_tb;
  localparam int unsigned WP = 20, P1L = 60, P1N = 50, PNL = 40, PNN = 30, ST = 80;
  localparam int unsigned LIMIT = 40000; // Cycle ceiling

  // Reset case: source, detector use, restart window, debug enable
  typedef struct {
    int unsigned src;
    logic        ctrl;
    int unsigned lo;
    int unsigned hi;
    logic        oe;
  } row_t;

  logic                          ref_clk_i, rst_n_i, external_reset_pin_n_i, por_detect_i;
  logic                          supply_level_detector_i, wdt_overflow_i, ram_parity_error_i;
  logic                          software_system_reset_request_i, illegal_access_i;
  logic                          osc_stop_reset_i, supply_detect_control_i, sleep_enter_i;
  rst_seq_pkg::clk_src_t         clk_src_i;
  logic [2:0]                    osc_settle_select_i;
  logic [rst_seq_pkg::IRQ_W-1:0] irq_pending_i, irq_mask_i;
  logic                          sys_reset_n_o, core_run_o, sleeping_o, reset_vector_fetch_o;
  logic                          core_irq_o, isr_start_o, core_clk_hoco_o, wdt_reset_o;
  logic                          detector_logic_reset_o, rtc_run_o, debug_port_pin_a_o;
  logic                          debug_port_pin_a_oe_o, debug_port_pin_b_o, debug_port_pin_b_oe_o;
  rst_seq_pkg::osc_en_t          osc_en_o;
  rst_seq_pkg::reset_sources_t   reset_cause_flags_o;
  logic [7:0]                    int_q;     // Internal sources from the bench
  int unsigned                   n_checks = 0, miscompares = 0, cyc = 0, n;
  row_t                          rows [12] = '{
    '{rst_seq_pkg::SRC_POR,  1'b1, ST + PNL, ST + PNL + 5, 1'b0},
    '{rst_seq_pkg::SRC_EXT,  1'b0, P1N, P1N + 5, 1'b0},
    '{rst_seq_pkg::SRC_EXT,  1'b1, PNL, PNL + 5, 1'b0},
    '{rst_seq_pkg::SRC_EXT,  1'b0, PNN, PNN + 5, 1'b0},
    '{rst_seq_pkg::SRC_POR,  1'b1, ST + PNL, ST + PNL + 5, 1'b0},
    '{rst_seq_pkg::SRC_EXT,  1'b1, P1L, P1L + 5, 1'b0},
    '{rst_seq_pkg::SRC_WDT,  1'b0, PNN, PNN + 5, 1'b1},
    '{rst_seq_pkg::SRC_LVD,  1'b1, PNL, PNL + 5, 1'b1},
    '{rst_seq_pkg::SRC_SW,   1'b0, PNN, PNN + 5, 1'b1},
    '{rst_seq_pkg::SRC_PAR,  1'b0, PNN, PNN + 5, 1'b1},
    '{rst_seq_pkg::SRC_ILL,  1'b0, PNN, PNN + 5, 1'b1},
    '{rst_seq_pkg::SRC_OSTP, 1'b0, PNN, PNN + 5, 1'b1}};

  // Internal sources to their pins
  assign wdt_overflow_i = int_q[rst_seq_pkg::SRC_WDT];
  assign software_system_reset_request_i = int_q[rst_seq_pkg::SRC_SW];
  assign ram_parity_error_i = int_q[rst_seq_pkg::SRC_PAR];
  assign illegal_access_i = int_q[rst_seq_pkg::SRC_ILL];
  assign osc_stop_reset_i = int_q[rst_seq_pkg::SRC_OSTP];

  rst_sequencer #(.WAKE_PREP_CYC(WP), .PROC_1L_CYC(P1L), .PROC_1N_CYC(P1N), .PROC_NL_CYC(PNL),
    .PROC_NN_CYC(PNN), .STAB_CYC(ST)) rst_sequencer_i (.*);

  reset_supply_model reset_supply_model_i (.ref_clk_i,
    .external_reset_pin_n_o(external_reset_pin_n_i), .por_detect_o(por_detect_i),
    .supply_level_detector_o(supply_level_detector_i));

  // 250 MHz clock
  initial begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end

  // Hang guard
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == LIMIT) begin
      miscompares++;
      conclude();
    end
  end

  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_checks++;
    if (seen !== want) begin
      miscompares++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, want);
    end
  endtask

  // Counts falling edges until a flag shows
  task automatic wait_flag(ref logic flag, input int unsigned lim);
    n = 0;
    do begin
      @(negedge ref_clk_i);
      n++;
    end while (flag !== 1'b1 && n < lim);
  endtask

  // One reset from raise to restart
  task automatic run_row(input row_t r);
    logic far;
    far = r.src inside {rst_seq_pkg::SRC_EXT, rst_seq_pkg::SRC_POR, rst_seq_pkg::SRC_LVD};
    @(posedge ref_clk_i);
    supply_detect_control_i <= r.ctrl;
    if (far) reset_supply_model_i.press(r.src);
    else int_q[r.src] <= 1'b1;
    repeat (3) @(negedge ref_clk_i);
    check(sys_reset_n_o, 1'b0);
    check(osc_en_o, rst_seq_pkg::OSC_ALL_OFF);
    check(wdt_reset_o, 1'b1);
    check({debug_port_pin_a_oe_o, debug_port_pin_b_oe_o}, {2{r.oe}});
    check(rtc_run_o, r.src != rst_seq_pkg::SRC_POR);
    check(detector_logic_reset_o, r.src != rst_seq_pkg::SRC_LVD);
    if (far) reset_supply_model_i.lift(r.src);
    else begin
      @(posedge ref_clk_i);
      int_q[r.src] <= 1'b0;
    end
    wait_flag(core_run_o, r.hi + 20);
    check(n >= r.lo && n <= r.hi, 1'b1);
    check(reset_vector_fetch_o, 1'b1);
    check(reset_cause_flags_o, 8'h01 << r.src);
    check({osc_en_o, core_clk_hoco_o}, {rst_seq_pkg::OSC_RUN_ON, 1'b1});
    check({debug_port_pin_a_o, debug_port_pin_b_o, debug_port_pin_a_oe_o,
      debug_port_pin_b_oe_o}, 4'hF);
  endtask

  // Sleep, stay asleep while masked, then wake
  task automatic wake(input rst_seq_pkg::clk_src_t cs, input int unsigned want);
    @(posedge ref_clk_i);
    clk_src_i <= cs;
    sleep_enter_i <= 1'b1;
    @(posedge ref_clk_i);
    sleep_enter_i <= 1'b0;
    irq_pending_i <= 32'h0000_0010;
    repeat (6) @(negedge ref_clk_i);
    check({sleeping_o, core_irq_o}, 2'h2);
    @(posedge ref_clk_i);
    irq_mask_i <= 32'hFFFF_FFEF; // Only the wake line opened
    wait_flag(core_irq_o, want + 20);
    check(n >= want && n <= want + 4, 1'b1);
    wait_flag(isr_start_o, 40);
    check(n, 14);
    @(posedge ref_clk_i);
    irq_pending_i <= '0;
    irq_mask_i <= '1;
  endtask

  // Counts, then the verdict
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Reset, table of resets, wakes, reset out of sleep
  initial begin
    rst_n_i = 1'b0;
    int_q = 8'h00;
    supply_detect_control_i = 1'b0;
    sleep_enter_i = 1'b0;
    clk_src_i = rst_seq_pkg::CLK_HOCO;
    osc_settle_select_i = 3'h1;
    irq_pending_i = '0;
    irq_mask_i = '1;
    repeat (10) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    wait_flag(core_run_o, 400);
    check({core_run_o, core_clk_hoco_o}, 2'h3);
    foreach (rows[i]) run_row(rows[i]);
    wake(rst_seq_pkg::CLK_HOCO, WP);
    wake(rst_seq_pkg::CLK_EXT, WP);
    wake(rst_seq_pkg::CLK_XTAL, 32'h100 << osc_settle_select_i);
    wake(rst_seq_pkg::CLK_PLL, WP + rst_seq_pkg::PLL_LOCK_CYC);
    @(posedge ref_clk_i);
    sleep_enter_i <= 1'b1;
    @(posedge ref_clk_i);
    sleep_enter_i <= 1'b0;
    run_row(rows[6]);
    conclude();
  end
endmodule
